//--- rfdt_field_model.sv
/*
 * Far-side model: antenna driver field-on settings and signal-in pin.
 * Assumes the bench raises fire to start a signal-in frame.
 */
`default_nettype none

module rfdt_field_model
(
   input wire logic mclk,
   input wire logic fire,
   output logic [3:0] unmod_n_cond_field_on,
   output logic [3:0] mod_n_cond_field_on,
   output logic secure_link_in_pin
);
   timeunit 1ns;
   timeprecision 1ps;

   // Field-on values live outside the block; fixed, distinct patterns
   assign unmod_n_cond_field_on = 4'h6;
   assign mod_n_cond_field_on = 4'h9;

   // Pin edge follows fire one mclk cycle later, through a single register
   always_ff @(posedge mclk)
      secure_link_in_pin <= fire;
endmodule : rfdt_field_model

`default_nettype wire

//--- rfdt_pkg.sv
/*
 * Constants, register map and state types for the RF driver timing
 * configuration block. Assumes one 40 MHz clock that stands for the
 * carrier, and an AXI4-Lite master that owns the register port.
 */
`default_nettype none

package rfdt_pkg;

   // ----------------------------------------------------------------
   // Register map (index; byte address is four times the index)
   // ----------------------------------------------------------------
   localparam int ADDR_W = 18;
   localparam logic [15:0] IDX_CTRL = 16'h6300;
   localparam logic [15:0] IDX_STAT = 16'h6301;
   localparam logic [15:0] IDX_GSNOFF = 16'h6313;
   localparam logic [15:0] IDX_MODW = 16'h6314;
   localparam logic [15:0] IDX_BITPH = 16'h6315;

   localparam logic [7:0] RST_GSNOFF = 8'h88;
   localparam logic [7:0] RST_MODW = 8'h26;
   localparam logic [7:0] RST_BITPH = 8'h87;
   localparam logic [12:0] RST_CTRL = 13'h0000;

   localparam int BP_CLK_BIT = 7;
   localparam int COND_TOP = 3;

   localparam logic [1:0] DRV_CODER = 2'h1;
   localparam logic [1:0] DRV_SECURE_LINK_IN_PIN = 2'h2;
   localparam logic [3:0] SECURE_LINK_OUT_PIN_DELAYED_SC = 4'hE;

   // ----------------------------------------------------------------
   // Timing counts in carrier cycles
   // ----------------------------------------------------------------
   localparam logic [9:0] DELAY_BIAS = 10'h087;
   localparam logic [9:0] SECURE_LINK_IN_PIN_EARLY = 10'h080;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic delayed_subcarrier_option;
      logic [3:0] signal_out_select;
      logic [1:0] transmit_wait_coarse;
      logic target_mode;
      logic power_down;
      logic [1:0] driver_source_select;
      logic driver_two_rf_enable;
      logic driver_one_rf_enable;
   } rfdt_ctrl_s;

   typedef enum logic [1:0] {
      DL_IDLE = 2'b01,
      DL_COUNT = 2'b10
   } rfdt_dly_e;

endpackage : rfdt_pkg

`default_nettype wire

//--- rfdt_top.sv
/*
 * RF driver timing configuration: N-driver conductance selection,
 * modulation pulse width, subcarrier duty cycle and bit-phase delay,
 * with an AXI4-Lite register slave. Assumes mclk is the carrier clock
 * and the coder strobes arrive on mclk; the signal-in pin is async.
 */
// The AXI4-Lite register port was chosen for this implementation.
`default_nettype none

module rfdt_top
   import rfdt_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [3:0] unmod_n_cond_field_on,
   input wire logic [3:0] mod_n_cond_field_on,
   input wire logic modulate,
   input wire logic tx_request,
   input wire logic miller_bit_edge,
   input wire logic secure_link_in_pin,
   output logic [3:0] n_cond_out,
   output logic miller_pulse,
   output logic subcarrier,
   output logic tx_start,
   output logic secure_link_out_pin,
   output logic demod_clock_from_field
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic awready;
      logic wready;
      logic aw_hold;
      logic [15:0] aw_idx;
      logic w_hold;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      rfdt_ctrl_s ctrl;
      logic [7:0] gsnoff;
      logic [7:0] modw;
      logic [7:0] bitph;
      logic [2:0] sync;
      logic secure_link_in_pin_lvl;
      rfdt_dly_e dly_state;
      logic [9:0] dly_cnt;
      logic [7:0] pulse_cnt;
      logic pulse;
      logic [3:0] sc_cnt;
      logic sc;
      logic sc_gate;
      logic tx_go;
      logic sig_out;
      logic [3:0] cond;
      logic clk_sel;
   } rfdt_state_s;

   rfdt_state_s s_reg;
   rfdt_state_s s_next;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] st);
      logic [15:0] r;
      r = old;
      if (st[0])
      begin
         r[7:0] = wd[7:0];
      end
      if (st[1])
      begin
         r[15:8] = wd[15:8];
      end
      return r;
   endfunction : merge16

   function automatic logic known_idx(input logic [15:0] idx);
      return (idx == IDX_CTRL) || (idx == IDX_STAT) ||
             (idx == IDX_GSNOFF) || (idx == IDX_MODW) ||
             (idx == IDX_BITPH);
   endfunction : known_idx

   // Combinational helpers over the registered state and port inputs
   logic field_on;
   logic force_top;
   logic [3:0] unmod_off_eff;
   logic [3:0] mod_off_eff;
   logic [9:0] dly_raw;
   logic [9:0] dly_load;
   logic secure_link_in_pin_rise;
   logic dly_trig;
   logic [15:0] rd_idx;
   logic [15:0] ctrl_w;

   always_comb
   begin
      // Field on when either driver generates RF
      field_on = s_reg.ctrl.driver_one_rf_enable |
                 s_reg.ctrl.driver_two_rf_enable;
      // Forcing stays internal; readback shows the stored value
      force_top = s_reg.ctrl.power_down &&
                  (s_reg.ctrl.driver_source_select != DRV_CODER);
      unmod_off_eff = s_reg.gsnoff[7:4];
      unmod_off_eff[COND_TOP] = s_reg.gsnoff[7] | force_top;
      mod_off_eff = s_reg.gsnoff[3:0];
      mod_off_eff[COND_TOP] = s_reg.gsnoff[3] | force_top;
      // {wait,phase} minus 135: wait 01 phase 1Bh gives 20 cycles,
      // wait 10 phase 0Fh gives 136; lower settings clamp to none
      dly_raw = {1'b0, s_reg.ctrl.transmit_wait_coarse,
                 s_reg.bitph[6:0]};
      dly_load = (dly_raw > DELAY_BIAS) ? 10'(dly_raw - DELAY_BIAS)
                                        : 10'h000;
      if (s_reg.ctrl.driver_source_select == DRV_SECURE_LINK_IN_PIN)
      begin
         // Signal-in arrives early, so the same settings stay valid
         dly_load = 10'(dly_load + SECURE_LINK_IN_PIN_EARLY);
      end
      secure_link_in_pin_rise = (s_reg.sync[1] == s_reg.sync[2]) && s_reg.sync[2] &&
                   !s_reg.secure_link_in_pin_lvl;
      dly_trig = ((s_reg.ctrl.driver_source_select == DRV_CODER) &&
                  tx_request) ||
                 ((s_reg.ctrl.driver_source_select == DRV_SECURE_LINK_IN_PIN) &&
                  secure_link_in_pin_rise);
      rd_idx = s_axi_araddr[ADDR_W-1:2];
      ctrl_w = merge16({3'h0, s_reg.ctrl}, s_reg.w_data, s_reg.w_strb);
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      s_next = s_reg;
      s_next.tx_go = 1'b0;

      // Register slave, write side
      if (s_reg.bvalid && s_axi_bready)
      begin
         s_next.bvalid = 1'b0;
      end
      if (s_axi_awvalid && s_reg.awready)
      begin
         s_next.aw_hold = 1'b1;
         s_next.aw_idx = s_axi_awaddr[ADDR_W-1:2];
      end
      if (s_axi_wvalid && s_reg.wready)
      begin
         s_next.w_hold = 1'b1;
         s_next.w_data = s_axi_wdata;
         s_next.w_strb = s_axi_wstrb;
      end
      if (s_reg.aw_hold && s_reg.w_hold && !s_reg.bvalid)
      begin
         s_next.aw_hold = 1'b0;
         s_next.w_hold = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp = known_idx(s_reg.aw_idx) ? RESP_OKAY : RESP_DECERR;
         unique case (s_reg.aw_idx)
            IDX_CTRL: s_next.ctrl = ctrl_w[12:0];
            IDX_GSNOFF:
               if (s_reg.w_strb[0])
               begin
                  s_next.gsnoff = s_reg.w_data[7:0];
               end
            IDX_MODW:
               if (s_reg.w_strb[0])
               begin
                  s_next.modw = s_reg.w_data[7:0];
               end
            IDX_BITPH:
               if (s_reg.w_strb[0])
               begin
                  s_next.bitph = s_reg.w_data[7:0];
               end
            default: ;
         endcase
      end
      s_next.awready = !s_next.aw_hold && !s_next.bvalid;
      s_next.wready = !s_next.w_hold && !s_next.bvalid;

      // Register slave, read side
      if (s_reg.rvalid && s_axi_rready)
      begin
         s_next.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_reg.arready)
      begin
         s_next.rvalid = 1'b1;
         s_next.rresp = known_idx(rd_idx) ? RESP_OKAY : RESP_DECERR;
         s_next.rdata = 32'h0000_0000;
         unique case (rd_idx)
            IDX_CTRL: s_next.rdata[12:0] = s_reg.ctrl;
            IDX_STAT: s_next.rdata[4:0] = {s_reg.sc_gate, s_reg.secure_link_in_pin_lvl,
               s_reg.pulse, s_reg.dly_state == DL_COUNT, field_on};
            IDX_GSNOFF: s_next.rdata[7:0] = s_reg.gsnoff;
            IDX_MODW: s_next.rdata[7:0] = s_reg.modw;
            IDX_BITPH: s_next.rdata[7:0] = s_reg.bitph;
            default: ;
         endcase
      end
      s_next.arready = !s_next.rvalid;

      // Signal-in pin: three stages, level taken when last two agree
      s_next.sync = {s_reg.sync[1:0], secure_link_in_pin};
      if (s_reg.sync[1] == s_reg.sync[2])
      begin
         s_next.secure_link_in_pin_lvl = s_reg.sync[2];
      end

      // Bit-phase delay ahead of transmission
      unique case (s_reg.dly_state)
         DL_IDLE:
            if (dly_trig)
            begin
               if (dly_load == 10'h000)
               begin
                  s_next.tx_go = 1'b1;
                  s_next.sc_gate = 1'b1;
               end
               else
               begin
                  s_next.dly_cnt = 10'(dly_load - 10'h001);
                  s_next.dly_state = DL_COUNT;
               end
            end
            else if (tx_request &&
                     (s_reg.ctrl.driver_source_select != DRV_CODER))
            begin
               // Other sources go out undelayed
               s_next.tx_go = 1'b1;
            end
         DL_COUNT:
            if (s_reg.dly_cnt == 10'h000)
            begin
               s_next.tx_go = 1'b1;
               s_next.sc_gate = 1'b1;
               s_next.dly_state = DL_IDLE;
            end
            else
            begin
               s_next.dly_cnt = 10'(s_reg.dly_cnt - 10'h001);
            end
      endcase
      if (!modulate && !s_next.tx_go)
      begin
         s_next.sc_gate = 1'b0;
      end

      // Miller pulse as initiator: high for width plus one cycles
      if (s_reg.pulse)
      begin
         if (s_reg.pulse_cnt == 8'h00)
         begin
            s_next.pulse = 1'b0;
         end
         else
         begin
            s_next.pulse_cnt = 8'(s_reg.pulse_cnt - 8'h01);
         end
      end
      else if (miller_bit_edge && !s_reg.ctrl.target_mode)
      begin
         s_next.pulse = 1'b1;
         s_next.pulse_cnt = s_reg.modw;
      end

      // Subcarrier as target or card: 16-cycle period
      if (s_reg.ctrl.target_mode && modulate)
      begin
         s_next.sc_cnt = 4'(s_reg.sc_cnt + 4'h1);
         // Low while count within (width mod 8), high for the rest
         s_next.sc = (s_reg.sc_cnt > {1'b0, s_reg.modw[2:0]});
      end
      else
      begin
         s_next.sc_cnt = 4'h0;
         s_next.sc = 1'b0;
      end

      // Signal-out: delayed subcarrier only for this selection
      if (s_reg.ctrl.signal_out_select == SECURE_LINK_OUT_PIN_DELAYED_SC)
      begin
         s_next.sig_out = s_reg.ctrl.delayed_subcarrier_option ?
                          (s_reg.sc & s_reg.sc_gate) : s_reg.sc;
      end
      else
      begin
         s_next.sig_out = 1'b0;
      end

      // Conductance word is passed on as a binary-weighted code
      if (field_on)
      begin
         s_next.cond = modulate ? mod_n_cond_field_on
                                : unmod_n_cond_field_on;
      end
      else
      begin
         s_next.cond = modulate ? mod_off_eff : unmod_off_eff;
      end

      s_next.clk_sel = s_reg.bitph[BP_CLK_BIT];
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         s_reg <= '0;
         s_reg.ctrl <= RST_CTRL;
         s_reg.gsnoff <= RST_GSNOFF;
         s_reg.modw <= RST_MODW;
         s_reg.bitph <= RST_BITPH;
         s_reg.dly_state <= DL_IDLE;
         s_reg.clk_sel <= RST_BITPH[BP_CLK_BIT];
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign s_axi_awready = s_reg.awready;
   assign s_axi_wready = s_reg.wready;
   assign s_axi_bresp = s_reg.bresp;
   assign s_axi_bvalid = s_reg.bvalid;
   assign s_axi_arready = s_reg.arready;
   assign s_axi_rdata = s_reg.rdata;
   assign s_axi_rresp = s_reg.rresp;
   assign s_axi_rvalid = s_reg.rvalid;
   assign n_cond_out = s_reg.cond;
   assign miller_pulse = s_reg.pulse;
   assign subcarrier = s_reg.sc;
   assign tx_start = s_reg.tx_go;
   assign secure_link_out_pin = s_reg.sig_out;
   assign demod_clock_from_field = s_reg.clk_sel;

endmodule : rfdt_top

`default_nettype wire

//--- rfdt_top_bench.sv
/*
 * Self-checking bench for rfdt_top over its AXI4-Lite port.
 * Assumes rfdt_field_model as far side and a 40 MHz clock.
 */
`default_nettype none

module rfdt_top_bench
   import rfdt_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready, modulate, fire;
   logic tx_request, miller_bit_edge, secure_link_in_pin, tx_start;
   logic miller_pulse, subcarrier, secure_link_out_pin;
   logic demod_clock_from_field;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb, unmod_n_cond_field_on, mod_n_cond_field_on;
   logic [3:0] n_cond_out;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [7:0] ctl[5] = '{8'h00, 8'h10, 8'h14, 8'h01, 8'h02};
   logic [3:0] cnd[10] = '{4'h3, 4'h5, 4'hB, 4'hD, 4'h3, 4'h5, 4'h6,
      4'h9, 4'h6, 4'h9};
   logic [7:0] wc[4] = '{8'h44, 8'h44, 8'h84, 8'h48};
   logic [7:0] ph[4] = '{8'h1B, 8'h7F, 8'h0F, 8'h1B};
   int dl[4] = '{20, 120, 136, 148};
   int errors = 0;
   int compares = 0;
   int n;
   int m;

   rfdt_top dut_u (.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .unmod_n_cond_field_on,
      .mod_n_cond_field_on, .modulate, .tx_request, .miller_bit_edge,
      .secure_link_in_pin, .n_cond_out, .miller_pulse, .subcarrier,
      .tx_start, .secure_link_out_pin, .demod_clock_from_field);

   rfdt_field_model field_u (.mclk, .fire, .unmod_n_cond_field_on,
      .mod_n_cond_field_on, .secure_link_in_pin);

   always #12.5 mclk = ~mclk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [15:0] idx, input logic [31:0] d,
                     input logic [1:0] resp);
      logic a;
      logic w;
      a = 1'b1;
      w = 1'b1;
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (a || w)
      begin
         @(posedge mclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
         a = a && !s_axi_awready;
         w = w && !s_axi_wready;
      end
      while (!s_axi_bvalid)
         @(posedge mclk);
      s_axi_bready <= 1'b0;
      chk(32'(s_axi_bresp), 32'(resp));
      // Let an edge pass so a following call never re-drives bready
      @(posedge mclk);
   endtask : wr

   task automatic rd(input logic [15:0] idx, input logic [31:0] exp,
                     input logic [1:0] resp);
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge mclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, exp);
      chk(32'(s_axi_rresp), 32'(resp));
      @(posedge mclk);
   endtask : rd

   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : give_verdict

   initial
   begin
      repeat (20000) @(posedge mclk);
      errors++;
      $display("Error at %0t: watchdog expired", $time);
      give_verdict();
   end

   initial
   begin
      {mclk, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, modulate, fire} = '0;
      {tx_request, miller_bit_edge, s_axi_awaddr, s_axi_araddr} = '0;
      s_axi_wdata = '0;
      s_axi_wstrb = 4'hF;
      rst = 1'b1;
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      rd(IDX_GSNOFF, 32'h88, RESP_OKAY);
      rd(IDX_MODW, 32'h26, RESP_OKAY);
      rd(IDX_BITPH, 32'h87, RESP_OKAY);
      chk(32'(demod_clock_from_field), 1);
      wr(16'h6320, 32'hFF, RESP_DECERR);
      rd(16'h6320, 0, RESP_DECERR);
      $display("Test reset and map done");
      wr(IDX_GSNOFF, 32'h35, RESP_OKAY);
      for (int i = 0; i < 10; i++)
      begin
         if (i % 2 == 0)
            wr(IDX_CTRL, 32'(ctl[i / 2]), RESP_OKAY);
         modulate <= i[0];
         repeat (3) @(posedge mclk);
         chk(32'(n_cond_out), 32'(cnd[i]));
      end
      modulate <= 1'b0;
      wr(IDX_CTRL, 32'h10, RESP_OKAY);
      rd(IDX_GSNOFF, 32'h35, RESP_OKAY);
      $display("Test conductance done");
      wr(IDX_CTRL, 0, RESP_OKAY);
      for (int w = 0; w < 13; w += 6)
      begin
         wr(IDX_MODW, 32'(w), RESP_OKAY);
         miller_bit_edge <= 1'b1;
         @(posedge mclk);
         miller_bit_edge <= 1'b0;
         n = 0;
         repeat (20) @(posedge mclk) n += int'(miller_pulse);
         chk(32'(n), 32'(w + 1));
      end
      $display("Test modulation width done");
      wr(IDX_CTRL, 32'h0E20, RESP_OKAY);
      for (int w = 10; w < 16; w += 5)
      begin
         wr(IDX_MODW, 32'(w), RESP_OKAY);
         modulate <= 1'b1;
         repeat (20) @(posedge mclk);
         n = 0;
         m = 0;
         repeat (32) @(posedge mclk)
         begin
            n += int'(subcarrier === 1'b0);
            m += int'(secure_link_out_pin === 1'b0);
         end
         chk(32'(n), 32'(2 * (w % 8 + 1)));
         chk(32'(m), 32'(2 * (w % 8 + 1)));
         modulate <= 1'b0;
      end
      // Delayed option: gate stays shut while no delay has completed
      wr(IDX_CTRL, 32'h1E20, RESP_OKAY);
      modulate <= 1'b1;
      n = 0;
      repeat (32) @(posedge mclk) n += int'(secure_link_out_pin !== 1'b0);
      chk(32'(n), 32'h0);
      modulate <= 1'b0;
      $display("Test subcarrier done");
      for (int i = 0; i < 4; i++)
      begin
         wr(IDX_CTRL, 32'(wc[i]), RESP_OKAY);
         wr(IDX_BITPH, 32'(ph[i]), RESP_OKAY);
         chk(32'(demod_clock_from_field), 0);
         if (i < 3)
            tx_request <= 1'b1;
         else
            fire <= 1'b1;
         n = 0;
         do
         begin
            @(posedge mclk);
            tx_request <= 1'b0;
            n++;
         end while (tx_start !== 1'b1 && n < 400);
         fire <= 1'b0;
         // Count runs from the request edge to the edge that sees the pulse
         if (i < 3)
            chk(32'(n), 32'(dl[i] + 2));
         else
            chk(32'(n >= dl[i] + 5 && n <= dl[i] + 8), 1);
      end
      $display("Test bit phase delay done");
      give_verdict();
   end
endmodule : rfdt_top_bench

`default_nettype wire

//--- rfdt_top_props.sv
/*
 * Port checker for rfdt_top.
 * Assumes write address and data are taken at the same edge.
 */
`default_nettype none

module rfdt_props
   import rfdt_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [3:0] unmod_n_cond_field_on,
   input wire logic [3:0] mod_n_cond_field_on,
   input wire logic modulate,
   input wire logic miller_bit_edge,
   input wire logic [3:0] n_cond_out,
   input wire logic miller_pulse,
   input wire logic subcarrier,
   input wire logic tx_start,
   input wire logic demod_clock_from_field
);
   timeunit 1ns;
   timeprecision 1ps;
   logic rf_on_reg;
   logic rf_on_next;

   default clocking @(posedge mclk);
   endclocking
   default disable iff (rst);

   // ------------------------------------------------------------
   // Shadow of the RF enables, taken from control writes
   // ------------------------------------------------------------
   always_comb
   begin
      rf_on_next = rf_on_reg;
      if (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
          s_axi_wready && s_axi_awaddr == {IDX_CTRL, 2'b00})
         rf_on_next = |s_axi_wdata[1:0];
   end

   always_ff @(posedge mclk or posedge rst)
      if (rst)
         rf_on_reg <= 1'b0;
      else
         rf_on_reg <= rf_on_next;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid) else $error("read not answered in one cycle");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before handshake");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before handshake");
   a_field_cond: assert property (
      rf_on_reg && $past(rf_on_reg) && $past(rf_on_reg, 2)
      |-> n_cond_out == ($past(modulate)
      ? $past(mod_n_cond_field_on) : $past(unmod_n_cond_field_on)))
      else $error("field-on conductance not applied");
   a_miller_cause: assert property (
      $rose(miller_pulse) |-> $past(miller_bit_edge))
      else $error("modulation pulse without bit edge");
   a_tx_single: assert property (tx_start |=> !tx_start)
      else $error("transmit start longer than one cycle");
   a_demod_write: assert property (
      $changed(demod_clock_from_field)
      |-> $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2))
      else $error("demodulator clock select changed without write");
   a_sub_idle: assert property (!modulate [*4] |-> !subcarrier)
      else $error("subcarrier active outside modulation");

   c_tx: cover property ($rose(tx_start));
   c_miller: cover property ($rose(miller_pulse));
   c_field: cover property (rf_on_reg && modulate);
endmodule : rfdt_props

bind rfdt_top rfdt_props props_u (.mclk, .rst, .s_axi_awaddr,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
   .s_axi_rready, .unmod_n_cond_field_on, .mod_n_cond_field_on,
   .modulate, .miller_bit_edge, .n_cond_out, .miller_pulse,
   .subcarrier, .tx_start, .demod_clock_from_field);

`default_nettype wire
